// ==== bench/sar_adc_serial_sequencer_test.sv ====
/*
 * Self-checking bench of the serial converter sequencer.
 * Assumes the host model in sarseq_host and a comparator that keeps a
 * trial bit while the sampled level is at or above the trial code.
 */
`timescale 1ns/100ps

module sar_adc_serial_sequencer_test;
	logic clk_sys, arst_n, shift_clock, serial_in, serial_out;
	logic resolution_pin, comp_in, acquire, hold, powered, mux_ok;
	logic [11:0] dac_code;
	logic [1:0] mux_pos;
	logic [2:0] mux_neg;
	logic res_valid, res_ready, res_overrun, go, busy;
	logic [15:0] res_data, lfsr, word;
	logic [7:0] ctrl_byte;
	logic [1:0] lead;
	logic [23:0] rx_bits;
	logic [11:0] analog;
	int edge_n, miscompares, compares;
	logic [15:0] exp_q[$];

	// Comparator of the analog core.
	assign comp_in = (analog >= dac_code);

	sarseq_top u_sarseq_top (
		.clk_sys(clk_sys), .arst_n(arst_n), .shift_clock(shift_clock),
		.serial_in(serial_in), .serial_out(serial_out),
		.resolution_pin(resolution_pin), .comp_in(comp_in),
		.dac_code(dac_code), .acquire(acquire), .hold(hold),
		.powered(powered), .mux_ok(mux_ok), .mux_pos(mux_pos),
		.mux_neg(mux_neg), .res_valid(res_valid), .res_data(res_data),
		.res_ready(res_ready), .res_overrun(res_overrun)
	);

	sarseq_host u_sarseq_host (
		.go(go), .ctrl_byte(ctrl_byte), .lead(lead), .busy(busy),
		.edge_n(edge_n), .rx_bits(rx_bits), .shift_clock(shift_clock),
		.serial_in(serial_in), .serial_out(serial_out)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Returns {valid, positive input, negative input}.
	function automatic logic [5:0] exp_mux(input logic [2:0] a,
			input logic sgl);
		logic [1:0] ch;
		ch = {a[1], a[2]};
		return {a[1] ^ a[0], ch, sgl ? 3'h4 : {1'b0, ch[1], ~ch[0]}};
	endfunction

	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [23:0] e,
			input logic [23:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	// Waits for frame edge n, or for the frame's end when n is 0.
	task automatic wait_for(input int n);
		for (int k = 0; k < 400; k++) begin
			// The host clears its edge count only after go rises.
			@(posedge clk_sys);
			if (n == 0 ? !busy : edge_n >= n) begin
				#1;
				return;
			end
		end
		chk("wait bound", 24'h000001, 24'h000000);
		conclude();
	endtask

	// Takes one result word, stalling at random when asked.
	task automatic take_word(input logic [15:0] e, input logic stall);
		for (int k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			if (res_valid === 1'b1 && res_ready === 1'b1) begin
				chk("res_data", e, res_data);
				// Ready drops so no word leaves while nobody is looking.
				#1 res_ready = 1'b0;
				return;
			end
			lfsr = lfsr_next(lfsr);
			#1 res_ready = stall ? lfsr[0] : 1'b1;
		end
		chk("res_valid bound", 24'h000001, 24'h000000);
		conclude();
	endtask

	// One conversion frame with checks along the way.
	task automatic run_frame(input logic [7:0] c, input logic [11:0] v);
		logic [5:0] m;
		logic [11:0] code;
		m = exp_mux(c[6:4], c[2]);
		code = (resolution_pin && c[3]) ? (v & 12'hFF0) : v;
		word = {c[2], c[6:4], code};
		@(posedge clk_sys);
		#1;
		analog = v;
		ctrl_byte = c;
		lead = lfsr[3:2];
		go = 1'b1;
		wait_for(7);
		go = 1'b0;
		chk("acquire", 24'h000001, acquire);
		chk("hold", 24'h000000, hold);
		wait_for(12);
		chk("hold", 24'h000001, hold);
		chk("acquire", 24'h000000, acquire);
		chk("powered", 24'h000001, powered);
		chk("mux_ok", m[5], mux_ok);
		if (m[5]) begin
			chk("mux_sel", m[4:0], {mux_pos, mux_neg});
		end
		wait_for(0);
		chk("rx_bits", {10'h000, code, 2'h0}, rx_bits);
	endtask

	// ----------------------------------------------------------------
	// Clock and sequence
	// ----------------------------------------------------------------
	// System clock of 100 ns.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Every channel code with both polarities, then a full buffer.
	initial begin
		arst_n = 1'b0;
		go = 1'b0;
		ctrl_byte = 8'h00;
		lead = 2'h0;
		res_ready = 1'b0;
		resolution_pin = 1'b0;
		analog = 12'h000;
		lfsr = 16'h0052;
		miscompares = 0;
		compares = 0;
		repeat (16) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		for (int i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			resolution_pin = lfsr[4];
			run_frame({1'b1, i[2:0], lfsr[5], i[3], i[1:0]},
				(i == 0) ? 12'h000 : (i == 15) ? 12'hFFF : lfsr[15:4]);
			take_word(word, 1'b0);
			chk("powered", i[1:0] == 2'h3, powered);
		end
		for (int j = 0; j < 19; j++) begin
			lfsr = lfsr_next(lfsr);
			run_frame({1'b1, lfsr[6:0]}, lfsr[15:4]);
			if (j < 18) begin
				exp_q.push_back(word);
			end
			repeat (12) @(posedge clk_sys);
			#1;
			chk("res_overrun", j == 18, res_overrun);
		end
		while (exp_q.size() > 0) begin
			take_word(exp_q.pop_front(), 1'b1);
		end
		repeat (3) @(posedge clk_sys);
		#1;
		chk("res_valid", 24'h000000, res_valid);
		conclude();
	end
endmodule

// ==== bench/sarseq_host.sv ====
/*
 * Host serial port model: clocks whole 24-edge frames on request.
 * Assumes the bench pulses go and waits for busy to fall.
 */
`timescale 1ns/100ps

module sarseq_host (
	// Frame request from the bench
	input wire logic go,
	input wire logic [7:0] ctrl_byte,
	input wire logic [1:0] lead,
	output logic busy,
	output int edge_n,
	output logic [23:0] rx_bits,
	// Serial link
	output logic shift_clock,
	output logic serial_in,
	input wire logic serial_out
);
	// One shift period; result bits are taken on the rising edge.
	task automatic tick(input logic b, input logic in_frame);
		serial_in = b;
		#62.5 shift_clock = 1'b1;
		if (in_frame) begin
			rx_bits = {rx_bits[22:0], serial_out};
			edge_n = edge_n + 1;
		end
		#62.5 shift_clock = 1'b0;
	endtask

	// The clock stands low between frames; a released line shows the inverse.
	initial begin
		shift_clock = 1'b0;
		serial_in = 1'b0;
		busy = 1'b0;
		edge_n = 0;
		rx_bits = 24'h000000;
		forever begin
			@(posedge go);
			busy = 1'b1;
			edge_n = 0;
			#17.3;
			repeat (lead) tick(1'b0, 1'b0);
			for (int i = 0; i < 24; i++) begin
				tick((i < 8) ? ctrl_byte[7 - i] : i[0], 1'b1);
			end
			serial_in = ~serial_in;
			busy = 1'b0;
		end
	end
endmodule

// ==== design/sarseq_pkg.sv ====
/*
 * Shared constants and types of the serial converter sequencer.
 * Assumes nothing of its surroundings; all design files refer to it by
 * scoped name only.
 */
package sarseq_pkg;

	// -----------------------------------------------------------------
	// Frame timing, counted in shift clocks
	// -----------------------------------------------------------------
	localparam int unsigned FRAME_CLKS = 24;
	localparam logic [4:0] CNT_ACQ = 5'h04;
	localparam logic [4:0] CNT_SGL = 5'h05;
	localparam logic [4:0] CNT_LAST_CTRL = 5'h07;
	localparam logic [4:0] CNT_FIRST_CONV = 5'h08;
	localparam logic [4:0] CNT_FRAME_END = 5'h17;

	// -----------------------------------------------------------------
	// Control byte and result layout
	// -----------------------------------------------------------------
	localparam logic [7:0] CTRL_AFTER_START = 8'h01;
	localparam int unsigned RES_BITS = 12;
	localparam int unsigned LSB_STEPS = 4096;
	localparam logic [11:0] DAC_MID = 12'h800;
	localparam logic [11:0] DAC_ZERO = 12'h000;
	localparam logic [11:0] BIT0_MASK = 12'h001;
	localparam logic [3:0] POS_MSB = 4'hB;
	localparam logic [3:0] POS_LSB_LONG = 4'h0;
	localparam logic [3:0] POS_LSB_SHORT = 4'h4;
	localparam logic [1:0] PD_KEEP_ON = 2'h3;
	localparam logic [2:0] NEG_COMMON = 3'h4;
	localparam logic [5:0] MUX_IDLE = 6'h04;

	// -----------------------------------------------------------------
	// Result buffer
	// -----------------------------------------------------------------
	localparam int unsigned FIFO_WIDTH = 16;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	// Sequencer states, Gray coded along the frame.
	typedef enum logic [2:0] {
		SQ_IDLE = 3'h0,
		SQ_CTRL = 3'h1,
		SQ_CONV = 3'h3,
		SQ_PRES = 3'h2,
		SQ_TAIL = 3'h6
	} sarseq_state_t;

endpackage

// ==== design/sarseq_top.sv ====
/*
 * Serial conversion sequencer with its result buffer.
 * Assumes a host that drives shift_clock through whole 24-clock frames,
 * an analog core whose comparator settles within one shift clock, and a
 * system-side consumer on clk_sys that drains results by valid/ready.
 */
// What this block does
// - A conversion frame is exactly 24 shift clocks.
// - Control byte shifts in over first eight clocks.
// - Multiplexer set, acquisition starts when channel known.
// - Hold and conversion start three clocks later.
// - Twelve decisions, thirteenth clock shows last bit.
// - Output low, clocks ignored in last three.
// - Single-ended codes route input to common return.
// - Differential codes select input pairs either polarity.
// - Result weights steps as reference over 4096.
// - Serial input ignored until high start bit.
// - Byte order: start, channel, resolution, polarity, power.
// - Resolution pin enables eight-bit option bit.
// - Power-down code 00 sleeps, 11 stays powered.
`timescale 1ns/100ps

// ---------------------------------------------------------------------
// Result buffer with registered output stage
// ---------------------------------------------------------------------
module sarseq_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic ov_q;
	logic [WIDTH-1:0] od_q;
	wire empty = (wr_q == rd_q);
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire push = in_valid && !full;
	wire pop = !empty && (!ov_q || out_ready);

	// Ready reflects real room, so a stalled consumer holds the source.
	assign in_ready = !full;
	assign out_valid = ov_q;
	assign out_data = od_q;

	// Storage array; written only while there is room.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers and the output stage that keeps the output a flip-flop.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
			ov_q <= pop || (ov_q && !out_ready);
			if (pop) begin
				od_q <= mem[rd_q[AW-1:0]];
			end
		end
	end
endmodule

// ---------------------------------------------------------------------
// Sequencer top
// ---------------------------------------------------------------------
module sarseq_top (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Serial link from the host
	input wire logic shift_clock,
	input wire logic serial_in,
	output logic serial_out,
	// Resolution pin, asynchronous to the link
	input wire logic resolution_pin,
	// Analog core
	input wire logic comp_in,
	output logic [11:0] dac_code,
	output logic acquire,
	output logic hold,
	output logic powered,
	output logic mux_ok,
	output logic [1:0] mux_pos,
	output logic [2:0] mux_neg,
	// Result stream on the system clock
	output logic res_valid,
	output logic [15:0] res_data,
	input wire logic res_ready,
	output logic res_overrun
);
	// Decode of channel bits and polarity into multiplexer settings.
	function automatic logic [5:0] sarseq_mux(input logic a2, input logic a1,
		input logic a0, input logic sgl);
		logic [2:0] neg;
		neg = sgl ? sarseq_pkg::NEG_COMMON : {1'b0, a1, ~a2};
		sarseq_mux = {a1 ^ a0, a1, a2, neg};
	endfunction

	// -----------------------------------------------------------------
	// Link domain state
	// -----------------------------------------------------------------
	sarseq_pkg::sarseq_state_t state_q;
	sarseq_pkg::sarseq_state_t state_d;
	logic [4:0] cnt_q;
	logic [7:0] ctrl_q;
	logic [3:0] pos_q;
	logic [11:0] dac_q;
	logic short_q;
	logic keep_q;
	logic last_dec_q;
	logic out_bit_q;
	logic dout_q;
	logic acq_q;
	logic hold_q;
	logic pwr_q;
	logic [5:0] mux_q;
	logic [15:0] res_hold_q;
	logic done_tgl_q;
	logic mode_s1_q;
	logic mode_s2_q;

	// Successive approximation step: keep or drop the trial bit.
	wire [11:0] trial_mask = sarseq_pkg::BIT0_MASK << pos_q;
	wire [3:0] pos_lsb = short_q ? sarseq_pkg::POS_LSB_SHORT
		: sarseq_pkg::POS_LSB_LONG;
	wire last_step = (pos_q == pos_lsb);
	wire [11:0] dac_kept = comp_in ? dac_q : (dac_q & ~trial_mask);
	wire [11:0] dac_next = last_step ? dac_kept
		: (dac_kept | (trial_mask >> 1));
	wire [5:0] mux_early = sarseq_mux(ctrl_q[2], ctrl_q[1], ctrl_q[0], 1'b1);
	wire [5:0] mux_full = sarseq_mux(ctrl_q[3], ctrl_q[2], ctrl_q[1],
		serial_in);
	wire start_seen = (state_q == sarseq_pkg::SQ_IDLE) && serial_in;
	wire in_ctrl = (state_q == sarseq_pkg::SQ_CTRL);
	wire in_conv = (state_q == sarseq_pkg::SQ_CONV);
	wire present = (state_q == sarseq_pkg::SQ_PRES)
		|| (in_conv && (cnt_q != sarseq_pkg::CNT_FIRST_CONV));

	// Frame sequencing over the fixed 24-clock frame.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sarseq_pkg::SQ_IDLE: begin
				if (serial_in) begin
					state_d = sarseq_pkg::SQ_CTRL;
				end
			end
			sarseq_pkg::SQ_CTRL: begin
				if (cnt_q == sarseq_pkg::CNT_LAST_CTRL) begin
					state_d = sarseq_pkg::SQ_CONV;
				end
			end
			sarseq_pkg::SQ_CONV: begin
				if (last_step) begin
					state_d = sarseq_pkg::SQ_PRES;
				end
			end
			sarseq_pkg::SQ_PRES: begin
				state_d = sarseq_pkg::SQ_TAIL;
			end
			sarseq_pkg::SQ_TAIL: begin
				if (cnt_q == sarseq_pkg::CNT_FRAME_END) begin
					state_d = sarseq_pkg::SQ_IDLE;
				end
			end
			default: begin
				state_d = sarseq_pkg::SQ_IDLE;
			end
		endcase
	end

	// Resolution pin crosses into the link domain through two flops.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= resolution_pin;
			mode_s2_q <= mode_s1_q;
		end
	end

	// State, frame counter and control byte shift register.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= sarseq_pkg::SQ_IDLE;
			cnt_q <= '0;
			ctrl_q <= '0;
		end else begin
			state_q <= state_d;
			if (start_seen) begin
				cnt_q <= 5'h01;
				ctrl_q <= sarseq_pkg::CTRL_AFTER_START;
			end else if (state_q != sarseq_pkg::SQ_IDLE) begin
				cnt_q <= cnt_q + 5'h01;
			end
			if (in_ctrl) begin
				ctrl_q <= {ctrl_q[6:0], serial_in};
			end
		end
	end

	// Mode options latched from the control byte as its bits arrive.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			short_q <= 1'b0;
			keep_q <= 1'b0;
			mux_q <= sarseq_pkg::MUX_IDLE;
		end else begin
			if (in_ctrl && (cnt_q == sarseq_pkg::CNT_ACQ)) begin
				mux_q <= mux_early;
			end
			if (in_ctrl && (cnt_q == sarseq_pkg::CNT_SGL)) begin
				mux_q <= mux_full;
				short_q <= mode_s2_q && ctrl_q[0];
			end
			if (in_ctrl && (cnt_q == sarseq_pkg::CNT_LAST_CTRL)) begin
				keep_q <= ({ctrl_q[0], serial_in} == sarseq_pkg::PD_KEEP_ON);
			end
		end
	end

	// Sample, hold and power controls of the analog core.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			acq_q <= 1'b0;
			hold_q <= 1'b0;
			pwr_q <= 1'b0;
		end else begin
			if (in_ctrl && (cnt_q == sarseq_pkg::CNT_ACQ)) begin
				acq_q <= 1'b1;
			end else if (in_ctrl && (cnt_q == sarseq_pkg::CNT_LAST_CTRL)) begin
				acq_q <= 1'b0;
				hold_q <= 1'b1;
			end else if (in_conv && last_step) begin
				hold_q <= 1'b0;
			end
			pwr_q <= keep_q || (state_d != sarseq_pkg::SQ_IDLE);
		end
	end

	// Approximation register and result hand-off to the system side.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			pos_q <= '0;
			dac_q <= sarseq_pkg::DAC_ZERO;
			last_dec_q <= 1'b0;
			res_hold_q <= sarseq_pkg::WORD_ZERO;
			done_tgl_q <= 1'b0;
		end else begin
			if (in_ctrl && (cnt_q == sarseq_pkg::CNT_LAST_CTRL)) begin
				pos_q <= sarseq_pkg::POS_MSB;
				dac_q <= sarseq_pkg::DAC_MID;
			end else if (in_conv) begin
				dac_q <= dac_next;
				last_dec_q <= comp_in;
				pos_q <= pos_q - 4'h1;
				if (last_step) begin
					res_hold_q <= {ctrl_q[2], ctrl_q[6:4], dac_kept};
					done_tgl_q <= ~done_tgl_q;
				end
			end
		end
	end

	// Result bit stream; the tail and idle clocks leave it low.
	always_ff @(posedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			out_bit_q <= 1'b0;
		end else begin
			out_bit_q <= present ? last_dec_q : 1'b0;
		end
	end

	// Output bit changes on the falling shift clock edge.
	always_ff @(negedge shift_clock or negedge arst_n) begin
		if (!arst_n) begin
			dout_q <= 1'b0;
		end else begin
			dout_q <= out_bit_q;
		end
	end

	assign serial_out = dout_q;
	assign dac_code = dac_q;
	assign acquire = acq_q;
	assign hold = hold_q;
	assign powered = pwr_q;
	assign mux_ok = mux_q[5];
	assign mux_pos = mux_q[4:3];
	assign mux_neg = mux_q[2:0];

	// -----------------------------------------------------------------
	// System domain: toggle crossing and buffer feed
	// -----------------------------------------------------------------
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic pend_q;
	logic ovr_q;
	logic [15:0] cap_q;
	logic fifo_ready;
	wire new_word = tgl_s2_q ^ tgl_s3_q;
	wire accept = pend_q && fifo_ready;

	// The held word is stable for at least 20 shift clocks after the toggle moves.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			pend_q <= 1'b0;
			ovr_q <= 1'b0;
			cap_q <= sarseq_pkg::WORD_ZERO;
		end else begin
			tgl_s1_q <= done_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			if (new_word && pend_q && !fifo_ready) begin
				ovr_q <= 1'b1;
			end else if (new_word) begin
				cap_q <= res_hold_q;
				pend_q <= 1'b1;
			end else if (accept) begin
				pend_q <= 1'b0;
			end
		end
	end

	assign res_overrun = ovr_q;

	sarseq_fifo #(
		.WIDTH(sarseq_pkg::FIFO_WIDTH),
		.DEPTH(sarseq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(pend_q),
		.in_data(cap_q),
		.in_ready(fifo_ready),
		.out_valid(res_valid),
		.out_data(res_data),
		.out_ready(res_ready)
	);

	// -----------------------------------------------------------------
	// Checks on the link side
	// -----------------------------------------------------------------
	a_frame_length: assert property (@(posedge shift_clock) disable iff
		(!arst_n) start_seen |-> ##23 (state_q == sarseq_pkg::SQ_TAIL)
		##1 (state_q == sarseq_pkg::SQ_IDLE))
		else $error("frame is not 24 clocks");
	a_start_ignore: assert property (@(posedge shift_clock) disable iff
		(!arst_n) (state_q == sarseq_pkg::SQ_IDLE) && !serial_in
		|=> (state_q == sarseq_pkg::SQ_IDLE))
		else $error("left idle without start bit");
	a_byte_shift: assert property (@(posedge shift_clock) disable iff
		(!arst_n) in_ctrl && (cnt_q == sarseq_pkg::CNT_LAST_CTRL)
		|=> (ctrl_q[0] == $past(serial_in)) && ctrl_q[7])
		else $error("control byte not shifted in");
	a_acq_start: assert property (@(posedge shift_clock) disable iff
		(!arst_n) in_ctrl && (cnt_q == sarseq_pkg::CNT_ACQ)
		|=> acq_q && !hold_q)
		else $error("acquisition did not start");
	a_hold_three: assert property (@(posedge shift_clock) disable iff
		(!arst_n) $rose(acq_q) |-> acq_q [*3] ##1 (hold_q && !acq_q))
		else $error("hold not three clocks after acquire");
	a_conv_twelve: assert property (@(posedge shift_clock) disable iff
		(!arst_n) $rose(hold_q) && !short_q
		|-> ##12 (state_q == sarseq_pkg::SQ_PRES))
		else $error("conversion not twelve clocks");
	a_tail_low: assert property (@(posedge shift_clock) disable iff
		(!arst_n) (state_q == sarseq_pkg::SQ_TAIL)
		&& ($past(state_q) == sarseq_pkg::SQ_TAIL) |-> !dout_q)
		else $error("output not low in tail");
	a_single_route: assert property (@(posedge shift_clock) disable iff
		(!arst_n) $rose(hold_q) && ctrl_q[2] && mux_q[5]
		|-> (mux_q[2:0] == sarseq_pkg::NEG_COMMON)
		&& (mux_q[4:3] == {ctrl_q[5], ctrl_q[6]}))
		else $error("single-ended route wrong");
	a_diff_pair: assert property (@(posedge shift_clock) disable iff
		(!arst_n) $rose(hold_q) && !ctrl_q[2] && mux_q[5]
		|-> (mux_q[2:0] == {1'b0, mux_q[4:3] ^ 2'h1}))
		else $error("differential pair wrong");
	a_short_width: assert property (@(posedge shift_clock) disable iff
		(!arst_n) (state_q == sarseq_pkg::SQ_PRES) && short_q
		|-> (dac_q[3:0] == 4'h0) && mode_s2_q)
		else $error("eight-bit result has low bits");
	a_power_frame: assert property (@(posedge shift_clock) disable iff
		(!arst_n) in_conv |-> pwr_q)
		else $error("unpowered during conversion");
	a_msb_first: assert property (@(posedge shift_clock) disable iff
		(!arst_n) ($past(state_q, 2) == sarseq_pkg::SQ_CONV)
		|-> (out_bit_q == $past(comp_in, 2)))
		else $error("result bit order wrong");
endmodule
